// ==== src/decs_top.sv ====
// Operation
// - Arm field 00 leaves breakpoints untouched
// - Arm 01: B arms trace, no B break
// - Arm 10: A arms B, no A break
// - Arm 11: no breaks, trace after A-then-B
// - Reset clears all control bits to zero
// - Halt request bit forces debug until cleared
// - Internal halt request only when enabled
// - Trace enable bit gates trace counting
// - Freeze select: B freezes FIFO, no break
// - FIFO stays frozen until frozen flag clears
// - Range invert picks inside or outside range
// - Low codes select access kind qualification
// - Codes 10001-10110 restrict to user accesses
// - Codes 11001-11110 restrict to supervisor accesses
// - Hardware halt flag on pin/internal entry
// - Requested halt flag on entry with bit set
// - Memory break flag on entry after request
// - Software break flag on instruction entry
// - Trace hit flag on trace-zero entry
// - Arm flags record sequential arming events
// - Flags clear on reset or go-leave exit
// - CPU state field: run, low power, debug
// - Go-leave releases CPU until new request
`timescale 1ns/1ps
`default_nettype none
`include "decs_cfg.svh"

module decs_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register access from the command decoder
  input wire logic ctrl_wr,
  input wire logic [31:0] ctrl_wdata,
  output logic [31:0] ctrl_rdata,
  output logic [15:0] status_rdata,
  input wire logic go_leave,
  // Halt request sources
  input wire logic internal_halt_req_n,
  input wire logic pin_halt_req_n,
  // CPU handshake
  input wire logic dbg_ack,
  input wire logic cpu_lowpower,
  input wire logic break_instruction,
  output logic dbg_req,
  output logic break_request,
  output logic debug_session,
  // Bus access attributes and comparator results
  input wire logic acc_valid,
  input wire logic acc_match_a,
  input wire logic acc_match_b,
  input wire logic acc_fetch,
  input wire logic acc_cof,
  input wire logic acc_write,
  input wire logic acc_user,
  // Breakpoint counter interface
  output logic qual_hit_a,
  output logic qual_hit_b,
  input wire logic break_instruction_occ_a,
  input wire logic break_instruction_occ_b,
  // Trace counter and PC FIFO interface
  input wire logic trace_zero,
  output logic trace_count_en,
  output logic fifo_freeze
);
  import decs_pkg::*;

  // Control fields
  decs_seq_t seq_q; // Sequential arming mode
  logic halt_q; // Unconditional halt request
  logic internal_halt_req_enable_q; // Internal request enable
  logic tme_q; // Trace enable
  logic fifo_freeze_select_q; // FIFO freeze select
  logic rca_q; // Range invert, A
  logic rcb_q; // Range invert, B
  logic [4:0] bca_q; // Qualifier code, A
  logic [4:0] bcb_q; // Qualifier code, B

  // Status flags
  logic hw_flag_q;
  logic req_flag_q;
  logic mem_flag_q;
  logic sw_flag_q;
  logic trace_flag_q;
  logic frz_flag_q;
  logic sqb_flag_q;
  logic sqa_flag_q;
  decs_cpu_t cpu_q; // Reported CPU state

  // Internal state
  logic ack_q; // Previous acknowledge, for entry edge
  logic mem_pend_q; // Break request issued since last exit
  logic trace_pend_q; // Trace count reached zero
  logic session_q; // Debug session in progress
  logic brk_q;
  logic tce_q;
  logic hit_a_q;
  logic hit_b_q;

  // Combinational terms
  logic entry; // First cycle of a debug entry
  logic int_req; // Gated internal request
  logic pin_req; // External pin request
  logic raw_a;
  logic raw_b;
  logic a_breaks; // A raises breaks in this mode
  logic b_normal; // B acts as a plain breakpoint
  logic b_gate; // B comparison allowed
  logic freeze_ev;
  logic arm_a_ev;
  logic arm_b_ev;
  logic brk_d;
  logic tce_d;

  // Attribute and range qualification of one comparator
  function automatic logic qualify(
    input logic [4:0] code,
    input logic inv,
    input logic match,
    input logic fetch,
    input logic cof,
    input logic write,
    input logic user
  );
    logic in_rng;
    logic priv_ok;
    logic kind_ok;
    in_rng = inv ? !match : match;
    // Privilege class from upper code bits
    case (code[4:3])
      `DECS_PRIV_ANY: priv_ok = 1'b1;
      `DECS_PRIV_USER: priv_ok = user;
      `DECS_PRIV_SUPER: priv_ok = !user;
      default: priv_ok = 1'b0;
    endcase
    // Access kind from lower code bits; x0000 disables
    case (code[2:0])
      `DECS_KIND_ANY: kind_ok = 1'b1;
      `DECS_KIND_FETCH: kind_ok = fetch;
      `DECS_KIND_DATA: kind_ok = !fetch;
      `DECS_KIND_COF: kind_ok = fetch && cof;
      `DECS_KIND_WRITE: kind_ok = !fetch && write;
      `DECS_KIND_READ: kind_ok = !fetch && !write;
      default: kind_ok = 1'b0;
    endcase
    qualify = in_rng && priv_ok && kind_ok;
  endfunction : qualify

  // Request sources; internal input is masked by its enable
  assign int_req = internal_halt_req_enable_q && !internal_halt_req_n;
  assign pin_req = !pin_halt_req_n;
  assign entry = dbg_ack && !ack_q;

  // Halt bit keeps requesting even after a go-leave exit
  assign dbg_req = halt_q || int_req || pin_req || trace_pend_q;

  // Qualified comparator hits, before counting
  assign raw_a = acc_valid && qualify(bca_q, rca_q, acc_match_a,
    acc_fetch, acc_cof, acc_write, acc_user);
  assign raw_b = acc_valid && qualify(bcb_q, rcb_q, acc_match_b,
    acc_fetch, acc_cof, acc_write, acc_user);

  // Mode decode for the sequencer
  always_comb begin
    a_breaks = 1'b1;
    b_normal = 1'b1;
    b_gate = 1'b1;
    tce_d = tme_q;
    case (seq_q)
      // Plain breakpoints and trace
      DECS_SEQ_OFF: begin
        a_breaks = 1'b1;
      end
      // B only arms trace
      DECS_SEQ_TRACE_AFTER_B: begin
        b_normal = 1'b0;
        tce_d = tme_q && sqb_flag_q;
      end
      // A only arms B
      DECS_SEQ_B_AFTER_A: begin
        a_breaks = 1'b0;
        b_gate = sqa_flag_q;
      end
      // A arms B, B arms trace, nothing breaks
      DECS_SEQ_BOTH: begin
        a_breaks = 1'b0;
        b_normal = 1'b0;
        b_gate = sqa_flag_q;
        tce_d = tme_q && sqb_flag_q;
      end
      default: begin
        a_breaks = 1'b0;
      end
    endcase
  end

  // Break and freeze events from counter occurrences
  // B occurrences are ignored while B comparison is still suspended
  assign brk_d = (break_instruction_occ_a && a_breaks) ||
    (break_instruction_occ_b && b_gate && b_normal && !fifo_freeze_select_q);
  assign freeze_ev = break_instruction_occ_b && b_gate && b_normal && fifo_freeze_select_q;
  assign arm_a_ev = break_instruction_occ_a && (seq_q == DECS_SEQ_B_AFTER_A ||
    seq_q == DECS_SEQ_BOTH);
  assign arm_b_ev = break_instruction_occ_b && b_gate &&
    (seq_q == DECS_SEQ_TRACE_AFTER_B || seq_q == DECS_SEQ_BOTH);

  // Control register writes from the command decoder
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      seq_q <= DECS_SEQ_OFF;
      halt_q <= 1'b0;
      internal_halt_req_enable_q <= 1'b0;
      tme_q <= 1'b0;
      fifo_freeze_select_q <= 1'b0;
      rca_q <= 1'b0;
      rcb_q <= 1'b0;
      bca_q <= 5'h00;
      bcb_q <= 5'h00;
    end else if (ctrl_wr) begin
      seq_q <= decs_seq_t'(ctrl_wdata[`DECS_SQC_LSB +: 2]);
      halt_q <= ctrl_wdata[`DECS_HALT_BIT];
      internal_halt_req_enable_q <= ctrl_wdata[`DECS_INTERNAL_HALT_REQ_ENABLE_BIT];
      tme_q <= ctrl_wdata[`DECS_TME_BIT];
      fifo_freeze_select_q <= ctrl_wdata[`DECS_FIFO_FREEZE_SELECT_BIT];
      rcb_q <= ctrl_wdata[`DECS_RCB_BIT];
      bcb_q <= ctrl_wdata[`DECS_BCB_LSB +: 5];
      rca_q <= ctrl_wdata[`DECS_RCA_BIT];
      bca_q <= ctrl_wdata[`DECS_BCA_LSB +: 5];
    end
  end

  // Registered sequencer outputs; one cycle behind the events
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      brk_q <= 1'b0;
      tce_q <= 1'b0;
      hit_a_q <= 1'b0;
      hit_b_q <= 1'b0;
    end else begin
      brk_q <= brk_d;
      tce_q <= tce_d;
      hit_a_q <= raw_a;
      hit_b_q <= raw_b && b_gate;
    end
  end

  // Entry edge tracking and CPU state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      cpu_q <= DECS_CPU_RUN;
    end else begin
      ack_q <= dbg_ack;
      // Debug takes precedence over low power
      if (dbg_ack) begin
        cpu_q <= DECS_CPU_HALTED;
      end else if (cpu_lowpower) begin
        cpu_q <= DECS_CPU_LOWPWR;
      end else begin
        cpu_q <= DECS_CPU_RUN;
      end
    end
  end

  // Pending causes; a new cause in the exit cycle survives
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_pend_q <= 1'b0;
      trace_pend_q <= 1'b0;
    end else begin
      mem_pend_q <= brk_q || (mem_pend_q && !go_leave);
      trace_pend_q <= (trace_zero && tce_q) ||
        (trace_pend_q && !go_leave);
    end
  end

  // Session lasts from first entry to a go-leave exit
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      session_q <= 1'b0;
    end else begin
      session_q <= entry || (session_q && !go_leave);
    end
  end

  // Entry cause flags; set wins over the exit clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hw_flag_q <= 1'b0;
      req_flag_q <= 1'b0;
      mem_flag_q <= 1'b0;
      sw_flag_q <= 1'b0;
      trace_flag_q <= 1'b0;
    end else begin
      hw_flag_q <= (entry && (int_req || pin_req)) ||
        (hw_flag_q && !go_leave);
      req_flag_q <= (entry && halt_q) ||
        (req_flag_q && !go_leave);
      mem_flag_q <= (entry && mem_pend_q) ||
        (mem_flag_q && !go_leave);
      sw_flag_q <= (entry && break_instruction) ||
        (sw_flag_q && !go_leave);
      trace_flag_q <= (entry && trace_pend_q) ||
        (trace_flag_q && !go_leave);
    end
  end

  // Freeze and arming flags; arm flags also hold arming state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      frz_flag_q <= 1'b0;
      sqa_flag_q <= 1'b0;
      sqb_flag_q <= 1'b0;
    end else begin
      frz_flag_q <= freeze_ev || (frz_flag_q && !go_leave);
      sqa_flag_q <= arm_a_ev || (sqa_flag_q && !go_leave);
      sqb_flag_q <= arm_b_ev || (sqb_flag_q && !go_leave);
    end
  end

  // Control readback; unimplemented bits read zero
  assign ctrl_rdata = {14'h0000, seq_q, halt_q, internal_halt_req_enable_q, tme_q, fifo_freeze_select_q,
    rcb_q, bcb_q, rca_q, bca_q};

  // Status readback
  always_comb begin
    status_rdata = 16'h0000;
    status_rdata[`DECS_ST_HW_BIT] = hw_flag_q;
    status_rdata[`DECS_ST_REQ_BIT] = req_flag_q;
    status_rdata[`DECS_ST_MEM_BIT] = mem_flag_q;
    status_rdata[`DECS_ST_SW_BIT] = sw_flag_q;
    status_rdata[`DECS_ST_TRACE_BIT] = trace_flag_q;
    status_rdata[`DECS_ST_FRZ_BIT] = frz_flag_q;
    status_rdata[`DECS_ST_SQB_BIT] = sqb_flag_q;
    status_rdata[`DECS_ST_SQA_BIT] = sqa_flag_q;
    status_rdata[`DECS_ST_PM_LSB +: 2] = cpu_q;
  end

  // Outputs to CPU, counters and FIFO
  assign break_request = brk_q;
  assign debug_session = session_q;
  assign qual_hit_a = hit_a_q;
  assign qual_hit_b = hit_b_q;
  assign trace_count_en = tce_q;
  assign fifo_freeze = frz_flag_q;

endmodule : decs_top

`default_nettype wire

// ==== src/decs_cfg.svh ====
`ifndef DECS_CFG_SVH
`define DECS_CFG_SVH

// Control register field positions
`define DECS_CTRL_RESET 32'h0000_0000
`define DECS_SQC_LSB 16
`define DECS_HALT_BIT 15
`define DECS_INTERNAL_HALT_REQ_ENABLE_BIT 14
`define DECS_TME_BIT 13
`define DECS_FIFO_FREEZE_SELECT_BIT 12
`define DECS_RCB_BIT 11
`define DECS_BCB_LSB 6
`define DECS_RCA_BIT 5
`define DECS_BCA_LSB 0

// Status register field positions
`define DECS_ST_HW_BIT 9
`define DECS_ST_REQ_BIT 8
`define DECS_ST_MEM_BIT 7
`define DECS_ST_SW_BIT 6
`define DECS_ST_TRACE_BIT 5
`define DECS_ST_FRZ_BIT 4
`define DECS_ST_SQB_BIT 3
`define DECS_ST_SQA_BIT 2
`define DECS_ST_PM_LSB 0

// Qualifier privilege classes, upper two code bits
`define DECS_PRIV_ANY 2'b00
`define DECS_PRIV_USER 2'b10
`define DECS_PRIV_SUPER 2'b11

// Qualifier access kinds, lower three code bits
`define DECS_KIND_ANY 3'h1
`define DECS_KIND_FETCH 3'h2
`define DECS_KIND_DATA 3'h3
`define DECS_KIND_COF 3'h4
`define DECS_KIND_WRITE 3'h5
`define DECS_KIND_READ 3'h6

`endif

// ==== src/decs_pkg.sv ====
`default_nettype none

package decs_pkg;

  // Sequential arming modes, in field order 00..11
  typedef enum logic [1:0] {
    DECS_SEQ_OFF,
    DECS_SEQ_TRACE_AFTER_B,
    DECS_SEQ_B_AFTER_A,
    DECS_SEQ_BOTH
  } decs_seq_t;

  // CPU state reported in status, in field order 00..10
  typedef enum logic [1:0] {
    DECS_CPU_RUN,
    DECS_CPU_LOWPWR,
    DECS_CPU_HALTED
  } decs_cpu_t;

endpackage : decs_pkg

`default_nettype wire

// ==== verification/decs_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// CPU side: finishes an instruction, then halts
module decs_cpu_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Requests from the block, and the go-leave exit
  input wire logic dbg_req,
  input wire logic break_request,
  input wire logic go_leave,
  // Halt handshake
  output logic dbg_ack
);
  logic pend_q; // Request latched, not yet taken
  logic [3:0] wait_q; // Cycles spent on the current instruction
  // Pulse requests are latched while running; one in a halted or go-leave cycle is dropped
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dbg_ack <= 1'h0;
      pend_q <= 1'h0;
      wait_q <= 4'h0;
    end else if (go_leave) begin
      dbg_ack <= 1'h0;
      pend_q <= 1'h0;
      wait_q <= 4'h0;
    end else if (!dbg_ack && (dbg_req || pend_q || break_request)) begin
      pend_q <= 1'h1;
      wait_q <= wait_q + 4'h1;
      if (wait_q == 4'(LAT)) begin
        dbg_ack <= 1'h1;
      end
    end
  end
endmodule : decs_cpu_model

`default_nettype wire

// ==== verification/decs_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the halt control block
module decs_top_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Registers
  input wire logic ctrl_wr,
  input wire logic [31:0] ctrl_wdata,
  input wire logic [31:0] ctrl_rdata,
  input wire logic [15:0] status_rdata,
  input wire logic go_leave,
  // Requests and CPU
  input wire logic internal_halt_req_n,
  input wire logic dbg_ack,
  input wire logic dbg_req,
  input wire logic break_request,
  input wire logic debug_session,
  // Events
  input wire logic break_instruction_occ_a,
  input wire logic break_instruction_occ_b,
  input wire logic fifo_freeze,
  input wire logic acc_valid,
  input wire logic acc_match_a,
  input wire logic qual_hit_a
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic [1:0] arm = ctrl_rdata[17:16]; // Arming mode in force
  sequence s_entry; !dbg_ack ##1 dbg_ack; endsequence
  sequence s_brk_a; break_instruction_occ_a && arm == 2'h0; endsequence
  property p_wr; ctrl_wr |=> ctrl_rdata == {14'h0, $past(ctrl_wdata[17:0])};
  endproperty
  a_wr: assert property (p_wr) else $error("bad readback");
  property p_halt; ctrl_rdata[15] |-> dbg_req; endproperty
  a_halt: assert property (p_halt) else $error("no halt req");
  property p_int; ctrl_rdata[14] && !internal_halt_req_n |-> dbg_req;
  endproperty
  a_int: assert property (p_int) else $error("int req lost");
  property p_brk; s_brk_a |=> break_request; endproperty
  a_brk: assert property (p_brk) else $error("no break");
  property p_none; arm == 2'h3 && (break_instruction_occ_a || break_instruction_occ_b) |=>
    !break_request; endproperty
  a_none: assert property (p_none) else $error("break in 11");
  property p_seqb; arm == 2'h3 && break_instruction_occ_b && !status_rdata[2] &&
    !status_rdata[3] |=> !status_rdata[3]; endproperty
  a_seqb: assert property (p_seqb) else $error("B armed before A");
  property p_frz; break_instruction_occ_b && !break_instruction_occ_a && ctrl_rdata[12] && arm == 2'h0
    |=> fifo_freeze && !break_request; endproperty
  a_frz: assert property (p_frz) else $error("no freeze");
  property p_hold; fifo_freeze && !go_leave |=> fifo_freeze; endproperty
  a_hold: assert property (p_hold) else $error("thawed");
  property p_clr; go_leave && !break_instruction_occ_a && !break_instruction_occ_b &&
    !(dbg_ack && !$past(dbg_ack)) |=> status_rdata[9:2] == 8'h0 &&
    !debug_session; endproperty
  a_clr: assert property (p_clr) else $error("flags kept");
  property p_pm; dbg_ack |=> status_rdata[1:0] == 2'h2; endproperty
  a_pm: assert property (p_pm) else $error("bad state");
  property p_req; s_entry ##0 ctrl_rdata[15] |=> status_rdata[8]; endproperty
  a_req: assert property (p_req) else $error("no req flag");
  property p_qual; acc_valid && (acc_match_a ^ ctrl_rdata[5]) &&
    ctrl_rdata[4:0] == 5'h1 |=> qual_hit_a; endproperty
  a_qual: assert property (p_qual) else $error("no hit");
endmodule : decs_top_assertions

bind decs_top decs_top_assertions i_decs_top_assertions (.*);

`default_nettype wire

// ==== verification/decs_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t %h %h", $time, (a), (e)); end end

module decs_top_tb_top;
  logic core_clk = 1'h0, rst_b = 1'h0, ctrl_wr = 1'h0, go_leave = 1'h0;
  logic int_n = 1'h1, pin_n = 1'h1, lowp = 1'h0, brk_ins = 1'h0;
  logic acc_valid = 1'h0, m_a = 1'h0, f = 1'h0, c = 1'h0, w = 1'h0;
  logic u = 1'h0, occ_a = 1'h0, occ_b = 1'h0, tz = 1'h0;
  logic [31:0] ctrl_wdata = 32'h0, ctrl_rdata;
  logic [15:0] status_rdata;
  logic dbg_ack, dbg_req, brk, sess, qa, qb, tce, frz;
  int fail_count = 0, n_tests = 0;
  always #10 core_clk = ~core_clk;
  decs_top i_decs_top (.core_clk(core_clk), .rst_b(rst_b),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .status_rdata(status_rdata), .go_leave(go_leave),
    .internal_halt_req_n(int_n), .pin_halt_req_n(pin_n),
    .dbg_ack(dbg_ack), .cpu_lowpower(lowp), .break_instruction(brk_ins),
    .dbg_req(dbg_req), .break_request(brk), .debug_session(sess),
    .acc_valid(acc_valid), .acc_match_a(m_a), .acc_match_b(m_a),
    .acc_fetch(f), .acc_cof(c), .acc_write(w), .acc_user(u),
    .qual_hit_a(qa), .qual_hit_b(qb), .break_instruction_occ_a(occ_a),
    .break_instruction_occ_b(occ_b), .trace_zero(tz), .trace_count_en(tce),
    .fifo_freeze(frz));
  decs_cpu_model i_decs_cpu_model (.core_clk(core_clk), .rst_b(rst_b),
    .dbg_req(dbg_req), .break_request(brk), .go_leave(go_leave),
    .dbg_ack(dbg_ack));
  task conclude;
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task cyc(input int n); repeat (n) @(posedge core_clk); #1; endtask : cyc
  task wr(input logic [31:0] d);
    @(posedge core_clk); ctrl_wr <= 1'h1; ctrl_wdata <= d;
    @(posedge core_clk); ctrl_wr <= 1'h0; #1;
  endtask : wr
  task gl;
    @(posedge core_clk); go_leave <= 1'h1;
    @(posedge core_clk); go_leave <= 1'h0; #1;
  endtask : gl
  task occ(input logic a, input logic b);
    @(posedge core_clk); occ_a <= a; occ_b <= b;
    @(posedge core_clk); occ_a <= 1'h0; occ_b <= 1'h0; #1;
  endtask : occ
  // Bounded wait for the CPU to halt, then let the flags land
  task enter;
    for (int i = 0; i < 40 && dbg_ack !== 1'h1; i++) cyc(1);
    if (dbg_ack !== 1'h1) begin fail_count++; conclude(); end
    cyc(2);
  endtask : enter
  // Expected qualifier outcome for one code and access
  function automatic logic qexp(logic [4:0] q, logic f, c, w, u);
    logic k;
    case (q[2:0])
      3'h1: k = 1'h1;
      3'h2: k = f;
      3'h3: k = !f;
      3'h4: k = f & c;
      3'h5: k = !f & w;
      3'h6: k = !f & !w;
      default: k = 1'h0;
    endcase
    case (q[4:3])
      2'h0: return k;
      2'h2: return k & u;
      2'h3: return k & !u;
      default: return 1'h0;
    endcase
  endfunction : qexp
  task t_reset;
    `CHK(ctrl_rdata, 32'h0)
    `CHK(status_rdata, 16'h0)
    wr(32'hffff_7fff);
    `CHK(ctrl_rdata, 32'h0003_7fff)
    wr(32'h0);
  endtask : t_reset
  task t_halt;
    wr(32'h8000); enter();
    `CHK(status_rdata[9:2], 8'h40)
    `CHK({sess, status_rdata[1:0]}, 3'h6)
    gl();
    `CHK(status_rdata[9:2], 8'h0)
    enter();
    `CHK(status_rdata[8], 1'h1)
    wr(32'h0); gl(); cyc(8);
    `CHK({sess, dbg_ack}, 2'h0)
  endtask : t_halt
  task t_pin;
    @(posedge core_clk); int_n <= 1'h0; brk_ins <= 1'h1; cyc(1);
    `CHK(dbg_req, 1'h0)
    wr(32'h4000);
    `CHK(dbg_req, 1'h1)
    enter();
    `CHK(status_rdata[9:2], 8'h90)
    @(posedge core_clk); int_n <= 1'h1; brk_ins <= 1'h0;
    wr(32'h0); gl();
    @(posedge core_clk); pin_n <= 1'h0; enter();
    `CHK(status_rdata[9], 1'h1)
    @(posedge core_clk); pin_n <= 1'h1; gl();
  endtask : t_pin
  task t_brk;
    occ(1'h1, 1'h0);
    `CHK(brk, 1'h1)
    enter();
    `CHK(status_rdata[7], 1'h1)
    gl();
    wr(32'h1000); occ(1'h0, 1'h1);
    `CHK(brk, 1'h0)
    cyc(6);
    `CHK({frz, status_rdata[4], dbg_ack}, 3'h6)
    gl();
    `CHK(frz, 1'h0)
  endtask : t_brk
  task t_seq;
    wr(32'h2_0000); occ(1'h0, 1'h1);
    `CHK(brk, 1'h0)
    occ(1'h1, 1'h0);
    `CHK({brk, status_rdata[2]}, 2'h1)
    occ(1'h0, 1'h1);
    `CHK(brk, 1'h1)
    enter(); gl();
    wr(32'h1_2000); cyc(1);
    `CHK(tce, 1'h0)
    occ(1'h0, 1'h1); cyc(1);
    `CHK({tce, status_rdata[3]}, 2'h3)
    wr(32'h0); gl(); wr(32'h3_2000); occ(1'h0, 1'h1); cyc(1);
    `CHK(tce, 1'h0)
    occ(1'h1, 1'h0); occ(1'h0, 1'h1);
    `CHK(brk, 1'h0)
    cyc(1);
    `CHK(tce, 1'h1)
    wr(32'h0); gl();
  endtask : t_seq
  task t_trace;
    wr(32'h2000); cyc(1);
    `CHK(tce, 1'h1)
    @(posedge core_clk); tz <= 1'h1;
    @(posedge core_clk); tz <= 1'h0; enter();
    `CHK(status_rdata[5], 1'h1)
    wr(32'h0); gl();
    @(posedge core_clk); lowp <= 1'h1; cyc(2);
    `CHK(status_rdata[1:0], 2'h1)
    @(posedge core_clk); lowp <= 1'h0;
  endtask : t_trace
  task t_qual;
    logic e;
    for (int m = 0; m < 2; m++) begin
      for (int q = 0; q < 32; q++) begin
        wr({20'h0, m[0], q[4:0], m[0], q[4:0]});
        for (int j = 0; j < 32; j++) begin
          if (j[1] && !j[0]) continue;
          @(posedge core_clk); acc_valid <= 1'h1; {m_a, u, w, c, f} <= j[4:0];
          cyc(1);
          e = (j[4] ^ m[0]) & qexp(q[4:0], j[0], j[1], j[2], j[3]);
          `CHK(qa, e)
          `CHK(qb, e)
          `CHK(qa, qb)
        end
      end
    end
    @(posedge core_clk); acc_valid <= 1'h0;
  endtask : t_qual
  initial begin
    cyc(10);
    @(posedge core_clk); rst_b <= 1'h1; cyc(1);
    t_reset(); t_halt(); t_pin(); t_brk(); t_seq(); t_trace(); t_qual();
    conclude();
  end
endmodule : decs_top_tb_top

`default_nettype wire
